// ===== logic/hpc_regs.sv
// Hub port configuration register bank with strap loading
// Notes on behaviour
// - Upper four bits of the three port masks ignore writes and read as zero.
// - Charging-support bit n governs downstream port n.
// - A charging-support one means the port offers charging features, zero means not.
// - Charging-support bits accept writes only for ports marked used.
// - Charging-support bits load from the charging straps at reset release.
// - Removable bit n reports whether the device on port n is removable.
// - Removable bits load from the removable straps at reset release.
// - Port-used bit n enables port n when one and disables it when zero.
// - Port-used bits load from the port-enable straps at reset release.
// - The string index zero answer carries the language low byte in its low byte.
// - The string index zero answer carries exactly one language code.
// - The language low byte takes writes only while custom strings are enabled.
`timescale 1ns/1ps
`default_nettype none
module hpc_regs
    import hpc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [3:0] charge_strap_pins_in,
    input wire logic [3:0] removable_strap_pins_in,
    input wire logic [3:0] port_enable_strap_pins_in,
    input wire logic custom_strings_enable_in,
    input wire hpc_pkg::hpc_wr_t wr_in,
    input wire logic [7:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    output logic rd_hit_out,
    output logic straps_loaded_out,
    output hpc_pkg::hpc_port_cfg_t port_cfg_out,
    output logic [15:0] lang_code_out,
    output logic [7:0] lang_count_out
);
    import hpc_pkg::*;

    hpc_state_t state_q;
    hpc_state_t state_d;
    logic [3:0] charge_q;
    wire logic [3:0] charge_d;
    logic [3:0] removable_q;
    wire logic [3:0] removable_d;
    logic [3:0] enabled_q;
    wire logic [3:0] enabled_d;
    logic [7:0] lang_low_q;
    wire logic [7:0] lang_low_d;
    wire logic [7:0] rd_data_d;
    wire logic rd_hit_d;

    // Load state lasts exactly one clock after reset release
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            HPC_ST_LOAD: state_d = HPC_ST_RUN;
            HPC_ST_RUN: state_d = HPC_ST_RUN;
        endcase
    end

    wire logic loading = (state_q == HPC_ST_LOAD);

    // Write decode; the load clock swallows any write presented with it
    wire logic wr_at_charge = (wr_in.addr == HPC_OFF_CHARGE);
    wire logic wr_at_removable = (wr_in.addr == HPC_OFF_REMOVABLE);
    wire logic wr_at_enabled = (wr_in.addr == HPC_OFF_ENABLED);
    wire logic wr_at_lang = (wr_in.addr == HPC_OFF_LANG_LOW);
    wire logic wr_ok = wr_in.wr_en && !loading;
    wire logic wr_charge = wr_ok && wr_at_charge;
    wire logic wr_removable = wr_ok && wr_at_removable;
    wire logic wr_enabled = wr_ok && wr_at_enabled;
    wire logic wr_lang = wr_ok && wr_at_lang && custom_strings_enable_in;
    // Only bits 3:0 are stored; upper write bits dropped
    wire logic [3:0] wr_field = wr_in.wdata[HPC_FIELD_MSB:0];

    // One slice per downstream port
    for (genvar port_idx = 0; port_idx < HPC_NUM_PORTS; port_idx++)
    begin : g_port
        // Gate on the used bit stored before this write, not the new byte
        wire logic port_used = enabled_q[port_idx];
        wire logic charge_take = wr_charge && port_used;
        wire logic charge_wr_bit = charge_take ? wr_field[port_idx] : charge_q[port_idx];
        wire logic removable_wr_bit = wr_removable ? wr_field[port_idx] : removable_q[port_idx];
        wire logic enabled_wr_bit = wr_enabled ? wr_field[port_idx] : enabled_q[port_idx];
        // Straps reach the bits on the load clock only, never again
        assign charge_d[port_idx] = loading ? charge_strap_pins_in[port_idx]
            : charge_wr_bit;
        assign removable_d[port_idx] = loading ? removable_strap_pins_in[port_idx]
            : removable_wr_bit;
        assign enabled_d[port_idx] = loading ? port_enable_strap_pins_in[port_idx]
            : enabled_wr_bit;
    end

    // Whole byte writable; no reserved bits in this register
    assign lang_low_d = wr_lang ? wr_in.wdata : lang_low_q;

    // Read decode; reserved upper nibble of each mask reads as zero
    wire logic rd_at_charge = (rd_addr_in == HPC_OFF_CHARGE);
    wire logic rd_at_removable = (rd_addr_in == HPC_OFF_REMOVABLE);
    wire logic rd_at_enabled = (rd_addr_in == HPC_OFF_ENABLED);
    wire logic rd_at_lang = (rd_addr_in == HPC_OFF_LANG_LOW);
    wire logic [7:0] charge_byte = {4'h0, charge_q};
    wire logic [7:0] removable_byte = {4'h0, removable_q};
    wire logic [7:0] enabled_byte = {4'h0, enabled_q};
    assign rd_hit_d = rd_at_charge || rd_at_removable || rd_at_enabled || rd_at_lang;
    // Decodes are one-hot, so an and-or select is enough
    assign rd_data_d = ({8{rd_at_charge}} & charge_byte)
        | ({8{rd_at_removable}} & removable_byte)
        | ({8{rd_at_enabled}} & enabled_byte)
        | ({8{rd_at_lang}} & lang_low_q);

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q <= HPC_ST_LOAD;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            charge_q <= HPC_MASK_RESET;
        end
        else
        begin
            charge_q <= charge_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            removable_q <= HPC_MASK_RESET;
        end
        else
        begin
            removable_q <= removable_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            enabled_q <= HPC_MASK_RESET;
        end
        else
        begin
            enabled_q <= enabled_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            lang_low_q <= HPC_LANG_LOW_RESET;
        end
        else
        begin
            lang_low_q <= lang_low_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rd_data_out <= 8'h00;
        end
        else
        begin
            rd_data_out <= rd_data_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rd_hit_out <= 1'b0;
        end
        else
        begin
            rd_hit_out <= rd_hit_d;
        end
    end

    assign straps_loaded_out = !loading;
    // Bit n of each field drives downstream port n
    assign port_cfg_out.charge_support_bits = charge_q;
    assign port_cfg_out.removable = removable_q;
    assign port_cfg_out.port_enable = enabled_q;
    // Single language entry at string index zero
    assign lang_code_out = {HPC_LANG_HIGH_FIXED, lang_low_q};
    assign lang_count_out = 8'h01;
endmodule : hpc_regs
`default_nettype wire

// ===== logic/hpc_pkg.sv
// Package for the hub port configuration register bank
package hpc_pkg;
    localparam int unsigned HPC_NUM_PORTS = 4;
    localparam logic [7:0] HPC_OFF_CHARGE = 8'h06;
    localparam logic [7:0] HPC_OFF_REMOVABLE = 8'h07;
    localparam logic [7:0] HPC_OFF_ENABLED = 8'h08;
    localparam logic [7:0] HPC_OFF_LANG_LOW = 8'h20;
    localparam logic [7:0] HPC_LANG_LOW_RESET = 8'h09;
    localparam logic [7:0] HPC_LANG_HIGH_FIXED = 8'h04;
    localparam logic [3:0] HPC_MASK_RESET = 4'h0;
    localparam int unsigned HPC_FIELD_MSB = 3;

    // One register write from the loader or the serial host
    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hpc_wr_t;

    // Per-port configuration seen by descriptor and port logic
    typedef struct packed {
        logic [3:0] charge_support_bits;
        logic [3:0] removable;
        logic [3:0] port_enable;
    } hpc_port_cfg_t;

    // Strap-load phase after reset release: one load clock, then run
    typedef enum logic [0:0] {
        HPC_ST_LOAD = 1'b0,
        HPC_ST_RUN = 1'b1
    } hpc_state_t;
endpackage : hpc_pkg

// ===== dv/hpc_regs_assertions.sv
// Assertions on the port configuration register bank
`timescale 1ns/1ps
`default_nettype none
module hpc_regs_chk
    import hpc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic custom_strings_enable_in,
    input wire logic rd_hit_out,
    input wire logic straps_loaded_out,
    input wire logic [7:0] rd_addr_in,
    input wire logic [7:0] rd_data_out,
    input wire logic [7:0] lang_count_out,
    input wire logic [15:0] lang_code_out,
    input wire hpc_pkg::hpc_wr_t wr_in,
    input wire hpc_pkg::hpc_port_cfg_t port_cfg_out
);
    import hpc_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    wire logic wv = wr_in.wr_en && straps_loaded_out;
    // Bit 5 of the offset marks the language byte
    AST_RESERVED_BITS: assert property (rd_hit_out && !$past(rd_addr_in[5]) |-> !rd_data_out[7:4])
        else $error("reserved bits");
    AST_CNT: assert property (lang_count_out == 8'h01) else $error("count");
    AST_HIGH: assert property (lang_code_out[15:8] == HPC_LANG_HIGH_FIXED)
        else $error("high byte");
    AST_LOCK: assert property (!custom_strings_enable_in |=> $stable(lang_code_out))
        else $error("language locked");
    AST_GATE: assert property (wv && wr_in.addr == HPC_OFF_CHARGE |=>
        !((port_cfg_out ^ $past(port_cfg_out)) & ~{$past(port_cfg_out.port_enable), 8'h00}))
        else $error("unused charge bit");
    AST_USED: assert property (wv && wr_in.addr == HPC_OFF_ENABLED |=>
        port_cfg_out.port_enable == $past(wr_in.wdata[3:0])) else $error("enable");
    AST_HOLD: assert property (!wr_in.wr_en && straps_loaded_out |=>
        $stable(port_cfg_out)) else $error("config moved");
    AST_LRD: assert property (!wv && rd_addr_in == HPC_OFF_LANG_LOW |=>
        rd_hit_out && rd_data_out == lang_code_out[7:0]) else $error("language read");
endmodule : hpc_regs_chk
`default_nettype wire

// ===== dv/hpc_host_model.sv
// Loader model that hands register writes to the bank
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model
    import hpc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire hpc_pkg::hpc_wr_t req_in,
    output var hpc_pkg::hpc_wr_t wr_out
);
    import hpc_pkg::*;
    // Idle cycles show inverted bytes so stale data never looks held
    initial wr_out = '0;
    always @(posedge ref_clk_in)
        wr_out <= req_in.wr_en ? req_in : {1'b0, ~wr_out[15:0]};
endmodule : hpc_host_model
`default_nettype wire

// ===== dv/tb.sv
// Bench for the port configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hpc_pkg::*;
    logic c = 1'b0, r = 1'b0, e = 1'b0, h, ld;
    logic [11:0] s, m, f;
    logic [7:0] a = 8'h00, g, d, lc;
    logic [15:0] l;
    logic [16:0] x = 17'h17F3D;
    hpc_wr_t q = '0, w;
    int err_total = 0, comparisons = 0, n = 0;
    hpc_host_model host (.ref_clk_in(c), .req_in(q), .wr_out(w));
    hpc_regs dut (.ref_clk_in(c), .resetn_in(r), .charge_strap_pins_in(s[11:8]),
        .removable_strap_pins_in(s[7:4]), .port_enable_strap_pins_in(s[3:0]),
        .custom_strings_enable_in(e), .wr_in(w), .rd_addr_in(a), .rd_data_out(d),
        .rd_hit_out(h), .straps_loaded_out(ld), .port_cfg_out(f), .lang_code_out(l),
        .lang_count_out(lc));
    initial forever #4 c = ~c;
    always @(posedge c) if (++n == 3000) end_of_test(1);
    function automatic logic [16:0] nx(logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction : nx
    function automatic logic [8:0] erd(logic [7:0] k);
        return k == HPC_OFF_LANG_LOW ? {1'b1, g} : k inside {[HPC_OFF_CHARGE:HPC_OFF_ENABLED]}
            ? {5'h10, 4'(m >> 4 * (HPC_OFF_ENABLED - k))} : 9'h000;
    endfunction : erd
    task automatic end_of_test(int t);
        err_total += t;
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic chk(string t, logic [27:0] p, logic [27:0] o);
        comparisons++;
        if (o !== p)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", t, p, o);
        end
    endtask : chk
    task automatic wr_rd(logic [7:0] k, logic [7:0] v);
        q = {1'b1, k, v};
        @(posedge c) #1 q.wr_en = 1'b0;
        @(posedge c) #1 a = k;
        if (k == HPC_OFF_CHARGE) m[11:8] = m[11:8] & ~m[3:0] | v[3:0] & m[3:0];
        if (k == HPC_OFF_REMOVABLE) m[7:4] = v[3:0];
        if (k == HPC_OFF_ENABLED) m[3:0] = v[3:0];
        if (k == HPC_OFF_LANG_LOW && e) g = v;
        @(posedge c) #1;
        chk("read", erd(k), {h, d});
        chk("cfg", {m, HPC_LANG_HIGH_FIXED, g}, {f, l});
        chk("status", {1'b1, 8'h01}, {ld, lc});
    endtask : wr_rd
    initial
    begin
        s = x[11:0];
        repeat (16) @(posedge c);
        #1 r = 1'b1;
        {m, g} = {s, HPC_LANG_LOW_RESET};
        // Straps move after the load edge and must not leak in
        @(posedge c) #1 s = ~s;
        wr_rd(8'h21, 8'h5A);
        wr_rd(HPC_OFF_ENABLED, 8'hF0);
        wr_rd(HPC_OFF_CHARGE, 8'hFF);
        repeat (40)
        begin
            repeat (11) x = nx(x);
            e = x[10];
            wr_rd(x[1:0] == 2'h3 ? HPC_OFF_LANG_LOW : HPC_OFF_CHARGE + x[1:0], x[9:2]);
        end
        // Second reset; a write riding on the load clock must be dropped
        r = 1'b0;
        s = x[12:1] | 12'h001;
        @(posedge c) #1 q = {1'b1, HPC_OFF_ENABLED, 8'h00};
        @(posedge c) #1 r = 1'b1;
        q.wr_en = 1'b0;
        {m, g} = {s, HPC_LANG_LOW_RESET};
        @(posedge c) #1 s = ~s;
        wr_rd(8'h21, 8'h00);
        end_of_test(0);
    end
endmodule : tb
bind hpc_regs hpc_regs_chk asrt (.*);
`default_nettype wire
